// ==== logic/prpin_pkg.sv ====
/*
 * Shared constants of the pin control block: reset values and timing.
 * Assumes a single 100 MHz core clock; all counts derive from it.
 */
package prpin_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int INT_HOLD_MS = 500;
	localparam int NS_PER_MS = 1000000;
	// Longest time, so round down; one cycle at the least
	localparam int INT_HOLD_CYCLES_RAW = INT_HOLD_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int INT_HOLD_CYCLES =
		(INT_HOLD_CYCLES_RAW < 1) ? 1 : INT_HOLD_CYCLES_RAW;
	localparam int TMR_W = 26;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic RST_STRAP = 1'b0;
	localparam logic RST_LOW = 1'b0;
	localparam logic RST_MGMT_READY = 1'b0;

endpackage

// ==== logic/prpin_tmr_if.sv ====
/*
 * Carrier between the pin controller and its interrupt hold timer.
 * Assumes both ends share core_clk_i.
 */
interface prpin_tmr_if;
	logic start; // Restart the hold window
	logic busy; // Hold window running

	modport ctl (output start, input busy);
	modport tmr (input start, output busy);
endinterface

// ==== logic/prpin_hold_tmr.sv ====
/*
 * Interrupt hold timer: busy for HOLD cycles after each start.
 * Assumes start is a one-cycle pulse in the core clock domain.
 */
module prpin_hold_tmr
	import prpin_pkg::*;
#(
	parameter int HOLD = INT_HOLD_CYCLES,
	parameter int W = TMR_W
) (
	input wire logic core_clk_i, // Core clock
	input wire logic reset_i, // Async reset, active high
	prpin_tmr_if.tmr tmr // Start and busy
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// ----------------------------------------------------------------
	// Down counter
	// ----------------------------------------------------------------
	// A new start mid-window restarts it, so the last event is held full
	assign cnt_next = tmr.start ? W'(HOLD) :
		(cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
	assign tmr.busy = (cnt_reg != '0);

	// Counter register
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Window length is exact
	a_hold_length: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		tmr.start |=> (cnt_reg == W'(HOLD)) && tmr.busy)
		else $error("hold timer not loaded with hold count");
endmodule

// ==== logic/prpin_top.sv ====
/*
 * Pin control of the transceiver: supply alarm, shared power-down input
 * and interrupt output, management write block strap, three indicators
 * with general purpose I/O on the first one.
 * Assumes all inputs synchronous to core_clk_i and reset_i derived from
 * the board reset input. Open-drain pins: enable high means pull low.
 */

// Contract
// - Abnormal supply current in normal operation pulls the alarm pin low.
// - A hardware reset returns every internal register to its reset value.
// - By default a low on the shared pin puts the device in power-down.
// - Management access stays usable while in power-down.
// - In interrupt mode the shared pin is an open-drain active-low output.
// - With writes strapped off, the interrupt holds 500 ms then clears.
// - First indicator shows activity, or acts as general purpose I/O.
// - Second indicator shows a gigabit link.
// - Third indicator shows link good at any speed.
// - Strap low allows management writes; strap high rejects them.
module prpin_top
	import prpin_pkg::*;
#(
	parameter int INT_HOLD = prpin_pkg::INT_HOLD_CYCLES // Hold window
) (
	input wire logic core_clk_i, // Core clock, 100 MHz
	input wire logic reset_i, // Async reset, active high
	input wire logic supply_fault_i, // Abnormal supply current seen
	output logic supply_alarm_out_o, // Alarm pin level, always low
	output logic supply_alarm_out_oe_o, // Alarm pin pulled low
	input wire logic int_mode_i, // Shared pin used as interrupt
	input wire logic sleep_request_in_i, // Shared pin level
	output logic sleep_request_in_o, // Shared pin level, always low
	output logic sleep_request_in_oe_o, // Shared pin pulled low
	output logic power_down_o, // Device in power-down
	input wire logic int_event_i, // Interrupt event pulse
	input wire logic status_read_i, // Event status register read pulse
	output logic int_pending_o, // Interrupt pending
	input wire logic mgmt_write_block_strap_i, // Write block strap
	input wire logic mgmt_write_req_i, // Management write request
	output logic mgmt_write_ok_o, // Write accepted pulse
	output logic mgmt_ready_o, // Management access usable
	input wire logic activity_i, // Receive or transmit activity
	input wire logic gig_link_i, // Gigabit link up
	input wire logic link_good_i, // Link good at any speed
	input wire logic io_function_select_i, // 1: first indicator is I/O
	input wire logic gpio_out_i, // I/O output value
	input wire logic gpio_oe_i, // I/O drive enable
	input wire logic activity_indicator_i, // First indicator pin level
	output logic activity_indicator_o, // First indicator pin value
	output logic activity_indicator_oe_o, // First indicator driven
	output logic gpio_in_o, // I/O input sample
	output logic gigabit_link_indicator_o, // Second indicator
	output logic link_good_indicator_o // Third indicator
);
	import prpin_pkg::*;

	prpin_tmr_if tmr_bus ();

	logic strap_reg;
	logic strap_done_reg;
	logic pending_reg;
	logic pending_next;
	logic irq_active;
	logic pd_next;
	logic alarm_next;
	logic act_next;
	logic act_oe_next;

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	// Caught at the first edge after release; async reset loads constants
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			strap_reg <= RST_STRAP;
			strap_done_reg <= RST_LOW;
		end else if (!strap_done_reg) begin
			strap_reg <= mgmt_write_block_strap_i;
			strap_done_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt source selection
	// ----------------------------------------------------------------
	// Strapped: a timed pulse, since software cannot acknowledge it
	assign tmr_bus.start = int_event_i && strap_reg;
	// Set beats the read clear in the same cycle
	assign pending_next = int_event_i ||
		(pending_reg && !status_read_i);
	assign irq_active = strap_reg ? tmr_bus.busy : pending_reg;

	prpin_hold_tmr #(
		.HOLD(INT_HOLD),
		.W(TMR_W)
	) u_hold (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.tmr(tmr_bus)
	);

	// ----------------------------------------------------------------
	// Pin and mode decode
	// ----------------------------------------------------------------
	assign pd_next = !int_mode_i && !sleep_request_in_i;
	// No alarm while powered down: supply draw is not normal there
	assign alarm_next = supply_fault_i && !power_down_o;
	assign act_next = io_function_select_i ? gpio_out_i : activity_i;
	assign act_oe_next = io_function_select_i ? gpio_oe_i : 1'b1;

	// Interrupt and power state
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pending_reg <= RST_LOW;
			sleep_request_in_oe_o <= RST_LOW;
			power_down_o <= RST_LOW;
		end else begin
			pending_reg <= pending_next && !strap_reg;
			sleep_request_in_oe_o <= int_mode_i && irq_active;
			power_down_o <= pd_next;
		end
	end

	// Management side stays alive in power-down
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mgmt_ready_o <= RST_MGMT_READY;
			mgmt_write_ok_o <= RST_LOW;
			int_pending_o <= RST_LOW;
		end else begin
			mgmt_ready_o <= 1'b1;
			mgmt_write_ok_o <= mgmt_write_req_i && !strap_reg;
			int_pending_o <= irq_active;
		end
	end

	// Open-drain levels of the alarm and shared pins
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			supply_alarm_out_o <= RST_LOW;
			supply_alarm_out_oe_o <= RST_LOW;
			sleep_request_in_o <= RST_LOW;
		end else begin
			supply_alarm_out_o <= 1'b0;
			supply_alarm_out_oe_o <= alarm_next;
			sleep_request_in_o <= 1'b0;
		end
	end

	// Status indicators and I/O sample
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			activity_indicator_o <= RST_LOW;
			activity_indicator_oe_o <= RST_LOW;
			gpio_in_o <= RST_LOW;
			gigabit_link_indicator_o <= RST_LOW;
			link_good_indicator_o <= RST_LOW;
		end else begin
			activity_indicator_o <= act_next;
			activity_indicator_oe_o <= act_oe_next;
			gpio_in_o <= activity_indicator_i;
			gigabit_link_indicator_o <= gig_link_i;
			link_good_indicator_o <= link_good_i;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	logic [31:0] irq_run_cnt;
	// Cycles the pin has been pulled low since the last event
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_run_cnt <= '0;
		end else if (int_event_i || !sleep_request_in_oe_o) begin
			irq_run_cnt <= '0;
		end else begin
			irq_run_cnt <= irq_run_cnt + 32'd1;
		end
	end

	sequence s_event_unread;
		int_event_i && !strap_reg ##1 !status_read_i;
	endsequence

	a_alarm_drive: assert property (supply_fault_i && !power_down_o
		|=> supply_alarm_out_oe_o && !supply_alarm_out_o)
		else $error("supply alarm not pulled low");
	a_reset_clean: assert property (disable iff (1'b0)
		reset_i |-> !sleep_request_in_oe_o && !power_down_o)
		else $error("outputs not at reset value");
	a_enter_sleep: assert property (
		!int_mode_i && !sleep_request_in_i
		|=> power_down_o ##0 !sleep_request_in_oe_o)
		else $error("power-down not entered");
	a_mgmt_alive: assert property (power_down_o && strap_done_reg
		|-> mgmt_ready_o)
		else $error("management lost in power-down");
	a_irq_pin: assert property (sleep_request_in_oe_o
		|-> $past(int_mode_i) && !sleep_request_in_o)
		else $error("shared pin driven outside interrupt mode");
	a_irq_window: assert property (!strap_reg
		|| irq_run_cnt <= 32'(INT_HOLD) + 32'd1)
		else $error("strapped interrupt held too long");
	a_irq_sticky: assert property (s_event_unread
		|-> pending_reg ##1 int_pending_o)
		else $error("interrupt dropped before status read");
	a_write_block: assert property (mgmt_write_req_i && strap_reg
		|=> !mgmt_write_ok_o)
		else $error("write taken while strapped off");
	a_act_default: assert property (!io_function_select_i
		|=> activity_indicator_oe_o
		&& activity_indicator_o == $past(activity_i))
		else $error("activity indicator wrong");
	a_link_leds: assert property (1'b1
		|=> gigabit_link_indicator_o == $past(gig_link_i)
		&& link_good_indicator_o == $past(link_good_i))
		else $error("link indicators wrong");
endmodule

// ==== tb/prpin_board.sv ====
/*
 * Board side of the pin block: pad pulls, power-down request, station poll.
 * Assumes the bench drives its random inputs just after core clock edges.
 */
module prpin_board (
	input wire logic core_clk_i, // Core clock
	input wire logic int_mode_i, // Shared pin used as interrupt
	input wire logic sleep_req_n_i, // Board asks for power-down when low
	input wire logic rd_en_i, // Station willing to poll this cycle
	input wire logic gpio_drive_i, // Board level on the first indicator
	input wire logic sleep_oe_i, // Device pulls shared pin low
	input wire logic act_i, // Device value on first indicator
	input wire logic act_oe_i, // Device drives first indicator
	input wire logic int_pending_i, // Pending flag seen by the station
	output logic sleep_pin_o, // Resolved shared pin level
	output logic act_pin_o, // Resolved first indicator level
	output logic status_read_o // Status register read pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Pads
	// ----------------------------------------------------------------
	// Pull-up wins unless someone pulls low; board lets go in int mode
	assign sleep_pin_o = !(sleep_oe_i | (!int_mode_i & !sleep_req_n_i));
	// Board drives the pad only while the device does not
	assign act_pin_o = act_oe_i ? act_i : gpio_drive_i;
	// Station reads the status register to learn the interrupt cause
	always @(posedge core_clk_i) begin
		status_read_o <= rd_en_i & int_pending_i;
	end
endmodule

// ==== tb/prpin_top_bench.sv ====
/*
 * Self-checking bench of the pin block with a cycle reference model.
 * Assumes the hand-over timing: outputs one edge after their cause, the interrupt outputs two edges after the event.
 */
module prpin_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 20;
	logic clk = 1'b0, rst = 1'b1, strap = 1'b0, mode = 1'b0;
	logic fault = 1'b0, sleep_n = 1'b1, evt = 1'b0, wr = 1'b0, rd_en = 1'b0;
	logic act = 1'b0, gig = 1'b0, lg = 1'b0, sel = 1'b0, gout = 1'b0;
	logic goe = 1'b0, gdrv = 1'b0;
	wire sleep_pin, act_pin, rd;
	wire [12:0] seen;
	logic [12:0] e = '0, q[$];
	logic pend = 1'b0, strap_r = 1'b0, first = 1'b0;
	int tmr = 0, n_mismatch = 0, total_checks = 0, seed = 32'h1d85eb8a;
	always #5 clk = ~clk;
	prpin_top #(.INT_HOLD(HOLD)) DUT (.core_clk_i(clk), .reset_i(rst),
		.supply_fault_i(fault), .supply_alarm_out_o(seen[12]),
		.supply_alarm_out_oe_o(seen[11]), .int_mode_i(mode),
		.sleep_request_in_i(sleep_pin), .sleep_request_in_o(seen[10]),
		.sleep_request_in_oe_o(seen[9]), .power_down_o(seen[8]),
		.int_event_i(evt), .status_read_i(rd), .int_pending_o(seen[7]),
		.mgmt_write_block_strap_i(strap), .mgmt_write_req_i(wr),
		.mgmt_write_ok_o(seen[6]), .mgmt_ready_o(seen[5]),
		.activity_i(act), .gig_link_i(gig), .link_good_i(lg),
		.io_function_select_i(sel), .gpio_out_i(gout), .gpio_oe_i(goe),
		.activity_indicator_i(act_pin), .activity_indicator_o(seen[4]),
		.activity_indicator_oe_o(seen[3]), .gpio_in_o(seen[2]),
		.gigabit_link_indicator_o(seen[1]), .link_good_indicator_o(seen[0]));
	prpin_board board (.core_clk_i(clk), .int_mode_i(mode),
		.sleep_req_n_i(sleep_n), .rd_en_i(rd_en), .gpio_drive_i(gdrv),
		.sleep_oe_i(seen[9]), .act_i(seen[4]), .act_oe_i(seen[3]),
		.int_pending_i(seen[7]), .sleep_pin_o(sleep_pin),
		.act_pin_o(act_pin), .status_read_o(rd));
	task automatic check(input string nm, input logic [12:0] s, x);
		total_checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Reference: note what each edge should produce
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		logic o;
		if (rst) begin
			e = '0;
			pend = 1'b0;
			tmr = 0;
			strap_r = 1'b0;
			first = 1'b1;
		end else begin
			// Timer wins with the strap set, else latched until read
			o = strap_r ? (tmr != 0) : pend;
			e[12:7] = {1'b0, fault & !e[8], 1'b0, o & mode,
				!mode & !sleep_pin, o};
			e[6:5] = {wr & !strap_r, 1'b1};
			e[4:3] = sel ? {gout, goe} : {act, 1'b1};
			e[2:0] = {act_pin, gig, lg};
			if (first)
				strap_r = strap;
			first = 1'b0;
			tmr = evt ? HOLD : (tmr != 0 ? tmr - 1 : 0);
			pend = evt | (pend & !rd);
		end
		q.push_back(e);
	end
	// ----------------------------------------------------------------
	// Monitor: compare once outputs have settled
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		logic [12:0] x;
		if (q.size() > 0) begin
			x = q.pop_front();
			if (rst)
				check("reset", seen, 13'h0000);
			else begin
				check("pins", 13'(seen[12:7]), 13'(x[12:7]));
				check("mgmt", 13'(seen[6:5]), 13'(x[6:5]));
				check("leds", 13'(seen[4:0]), 13'(x[4:0]));
			end
		end
	end
	// Every strap and mode pairing; one reset long enough for the board
	initial begin
		for (int p = 0; p < 4; p++) begin
			// Let the last random inputs land before the defaults replace them
			@(posedge clk);
			rst <= 1'b1;
			strap <= p[0];
			mode <= p[1];
			{fault, sleep_n, evt, wr, rd_en} <= 5'b01000;
			{act, gig, lg, sel, gout, goe, gdrv} <= '0;
			repeat ((p == 2) ? 100 : 6) @(posedge clk);
			rst <= 1'b0;
			repeat (2) @(posedge clk);
			repeat (400) begin
				@(posedge clk);
				fault <= 1'($random(seed));
				sleep_n <= ($random(seed) & 3) != 0;
				evt <= ($random(seed) & 31) == 0;
				{wr, rd_en, act, gig, lg, gout, goe, gdrv} <= 8'($random(seed));
				sel <= ($random(seed) & 7) == 0;
			end
		end
		final_report();
	end
	// Watchdog well beyond the planned run length
	initial begin
		#50000;
		n_mismatch++;
		final_report();
	end
endmodule
